// *** design/fpm_pkg.sv ***
// Shared constants for the flash protect and memory select block.
// Assumes a 250 MHz core clock and an 8-bit MCU register interface.
package fpm_pkg;

    localparam int          CLK_MHZ           = 250;
    localparam int          RECOVER_US        = 25;
    localparam int          RECOVER_CYC       = RECOVER_US * CLK_MHZ;
    localparam int          SLOW_RESET_MS     = 2;
    localparam int          SLOW_RESET_CYC    = SLOW_RESET_MS * 1000 * CLK_MHZ;
    localparam int          ERASE_CYC         = 4096;
    localparam int          PROG_CYC          = 64;

    localparam logic [11:0] UNLOCK_ADDR1      = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2      = 12'hAAA;
    localparam logic [7:0]  UNLOCK_DATA1      = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2      = 8'h55;
    localparam logic [7:0]  CMD_RESET         = 8'hF0;
    localparam logic [7:0]  CMD_PROGRAM       = 8'hA0;
    localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h80;
    localparam logic [7:0]  CMD_BULK          = 8'h10;
    localparam logic [7:0]  CMD_SECTOR        = 8'h30;

    // Register offsets within the control register space
    localparam logic [7:0]  OFS_MAIN_PROT     = 8'hC0;
    localparam logic [7:0]  OFS_SEC_PROT      = 8'hC2;
    localparam logic [7:0]  OFS_SPACE_MAP     = 8'hE2;

    // Space mapping fields
    localparam int          MAP_FETCH_RAM     = 0;
    localparam int          MAP_FETCH_SEC     = 1;
    localparam int          MAP_FETCH_MAIN    = 2;
    localparam int          MAP_READ_SEC      = 3;
    localparam int          MAP_READ_MAIN     = 4;
    localparam logic [4:0]  MAP_RESET         = 5'h0C;

    localparam int          SEC_SECURITY_BIT  = 7;
    localparam int          MAIN_SECTORS      = 8;
    localparam int          SECOND_SECTORS    = 4;

    typedef enum logic [2:0] {
        FPM_IDLE,
        FPM_UNLOCK1,
        FPM_UNLOCK2,
        FPM_ERASE1,
        FPM_ERASE2,
        FPM_ERASE3
    } fpm_cmd_t;

    typedef enum logic [1:0] {
        FPM_READ,
        FPM_PROG,
        FPM_BULK,
        FPM_SECT
    } fpm_op_t;

endpackage

// *** design/fpm_sel_if.sv ***
// Carries decoded selects between the decoder and the main module.
// Assumes single clock, combinational selects.
`timescale 1ns/1ns
`default_nettype none
interface fpm_sel_if;
    logic [7:0] main_sector_select;
    logic [3:0] second_sector_select;
    logic       ram_select;
    logic       control_register_space;
    logic [7:0] main_hit;
    logic [3:0] second_hit;
    logic       ram_hit;
    logic       csr_hit;
    modport dec (input main_sector_select, second_sector_select, ram_select,
                 control_register_space,
                 output main_hit, second_hit, ram_hit, csr_hit);
    modport top (output main_sector_select, second_sector_select, ram_select,
                 control_register_space,
                 input main_hit, second_hit, ram_hit, csr_hit);
endinterface
`default_nettype wire

// *** design/fpm_select_prio.sv ***
// Priority resolution of raw memory selects.
// Assumes raw selects come from the address decode logic.
`timescale 1ns/1ns
`default_nettype none
module fpm_select_prio
(
    fpm_sel_if.dec sel
);
    logic any_top;
    logic any_second;

    always_comb
    begin
        // Ram and register space outrank every flash sector
        any_top    = sel.ram_select | sel.control_register_space;
        any_second = |sel.second_sector_select;
        sel.ram_hit    = sel.ram_select;
        sel.csr_hit    = sel.control_register_space & ~sel.ram_select;
        sel.second_hit = any_top ? 4'h0 : sel.second_sector_select;
        sel.main_hit   = (any_top | any_second) ? 8'h00
                       : sel.main_sector_select;
    end
endmodule
`default_nettype wire

// *** design/fpm_top.sv ***
// Flash protection, flash command/reset control and memory select gating.
// Assumes MCU strobes are synchronous one-cycle pulses, selects from the
// address decode logic, and protection bits held in non-volatile config.
// Functional notes
// - Each main and secondary sector can be protected against program/erase.
// - Program or erase aimed at a protected sector is silently dropped.
// - Verify read of a protected sector returns its stored data.
// - Protection bits are MCU readable only; changed by test port.
// - Main protect status: bit i set means main sector i protected.
// - Secondary status bits 3..0 are sector protects; bits 6..4 unused.
// - Secondary status bit 7 reports the security bit.
// - Flash reset is one write, optionally after the two unlock writes.
// - Flash reset is ignored during byte program or bulk erase.
// - Slow variant: reset returns to read in milliseconds, aborts sector erase.
// - Fast variant: reset immediate; after error or erase abort, 25 us.
// - Reset pin aborts operations; read mode within 25 us if busy.
// - Sram responds only while its select is high.
// - Battery-on output high while the battery powers the sram.
// - Secondary sector wins over an overlapping main sector.
// - Sram and register space win over any flash sector.
// - Code access qualified by fetch strobe, data by read strobe.
// - Space map bits allow fetch from sram and fetch/read of each flash array.
// - Space map loads a configured boot value; MCU may rewrite it.
// - Error bit sets on a program timeout while a byte program runs.
`timescale 1ns/1ns
`default_nettype none
module fpm_top
#(
    parameter bit          FAST_VARIANT = 1'b1,
    parameter int          RECOVER_CYCLES = fpm_pkg::RECOVER_CYC,
    parameter int          SLOW_CYCLES    = fpm_pkg::SLOW_RESET_CYC,
    parameter logic [4:0]  MAP_BOOT       = fpm_pkg::MAP_RESET
)
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,

    // Reset pin pulse
    input  wire logic        i_reset_pin_b,

    // MCU bus
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_fetch,

    // Raw selects from address decode logic
    input  wire logic [7:0]  i_main_sector_select,
    input  wire logic [3:0]  i_second_sector_select,
    input  wire logic        i_ram_select,
    input  wire logic        i_control_register_space,

    // Non-volatile configuration and test port
    input  wire logic [7:0]  i_cfg_main_prot,
    input  wire logic [3:0]  i_cfg_second_prot,
    input  wire logic        i_cfg_security,
    input  wire logic        i_test_prot_load,

    // Flash array feedback
    input  wire logic [7:0]  i_flash_rdata,
    input  wire logic        i_prog_timeout,

    // Power
    input  wire logic        i_batt_cfg,
    input  wire logic        i_supply_below_batt,

    // Outputs
    output logic [7:0]       o_rdata,
    output logic [7:0]       o_main_access,
    output logic [3:0]       o_second_access,
    output logic             o_ram_access,
    output logic             o_csr_access,
    output logic             o_flash_prog,
    output logic             o_flash_erase,
    output logic [11:0]      o_flash_sectors,
    output logic             o_busy,
    output logic             o_error_status_bit,
    output logic             o_battery_on
);
    import fpm_pkg::*;

    typedef struct packed {
        fpm_cmd_t    cmd;
        fpm_op_t     op;
        logic [7:0]  main_prot;
        logic [3:0]  second_prot;
        logic        security;

        logic [4:0]  space_map;
        logic [31:0] op_cnt;
        logic [31:0] rec_cnt;
        logic        err;
        logic        busy;

        logic [7:0]  rdata;
        logic [7:0]  main_acc;
        logic [3:0]  second_acc;
        logic        ram_acc;
        logic        csr_acc;
        logic        prog;
        logic        erase;
        logic [11:0] sectors;

        logic        batt;
        logic        loaded;
    } fpm_state_t;

    fpm_state_t r;
    fpm_state_t next_r;

    fpm_sel_if sel ();
    fpm_select_prio u_prio
    (
        .sel (sel)
    );

    logic        strobe;
    logic        flash_wr;
    logic [11:0] tgt;
    logic [11:0] prot_all;
    logic        tgt_prot;

    assign sel.main_sector_select     = i_main_sector_select;
    assign sel.second_sector_select   = i_second_sector_select;
    assign sel.ram_select             = i_ram_select;
    assign sel.control_register_space = i_control_register_space;

    always_comb
    begin
        next_r   = r;
        strobe   = i_rd | i_fetch;
        tgt      = {sel.second_hit, sel.main_hit};
        prot_all = {r.second_prot, r.main_prot};
        tgt_prot = |(tgt & prot_all);
        flash_wr = i_wr & (|tgt);

        next_r.prog  = 1'b0;
        next_r.erase = 1'b0;

        // Protect bits come only from config or the test port
        if (!r.loaded || i_test_prot_load)
        begin
            next_r.main_prot   = i_cfg_main_prot;
            next_r.second_prot = i_cfg_second_prot;
            next_r.security    = i_cfg_security;
            next_r.loaded      = 1'b1;
        end

        // Gating by strobe and space map
        next_r.ram_acc = sel.ram_hit & (i_wr | i_rd
                       | (i_fetch & r.space_map[MAP_FETCH_RAM]));
        next_r.csr_acc = sel.csr_hit & (i_wr | i_rd);
        next_r.main_acc = sel.main_hit & {8{
            (i_fetch & r.space_map[MAP_FETCH_MAIN])
          | (i_rd & r.space_map[MAP_READ_MAIN])}};
        next_r.second_acc = sel.second_hit & {4{
            (i_fetch & r.space_map[MAP_FETCH_SEC])
          | (i_rd & r.space_map[MAP_READ_SEC])}};

        // Register reads; flash reads pass stored data even if protected
        next_r.rdata = 8'h00;
        if (sel.csr_hit && i_rd)
        begin
            case (i_addr[7:0])
                OFS_MAIN_PROT: next_r.rdata = r.main_prot;
                OFS_SEC_PROT:  next_r.rdata = {r.security, 3'h0,
                                               r.second_prot};
                OFS_SPACE_MAP: next_r.rdata = {3'h0, r.space_map};
                default:       next_r.rdata = 8'h00;
            endcase
        end
        else if (strobe && (|tgt))
        begin
            next_r.rdata = r.err ? {2'h0, 1'b1, 5'h00}
                                 : i_flash_rdata;
        end

        // Upper bits are simply not stored
        if (sel.csr_hit && i_wr && i_addr[7:0] == OFS_SPACE_MAP)
        begin
            next_r.space_map = i_wdata[4:0];
        end

        // Operation timing
        if (r.rec_cnt != 32'h0)
        begin
            next_r.rec_cnt = r.rec_cnt - 32'h1;
        end

        if (r.op != FPM_READ)
        begin
            if (i_prog_timeout && r.op == FPM_PROG)
            begin
                next_r.err = 1'b1;
            end
            if (r.op_cnt != 32'h0)
            begin
                next_r.op_cnt = r.op_cnt - 32'h1;
            end
            else
            begin
                next_r.op = FPM_READ;
            end
        end

        // Command sequencer
        if (flash_wr)
        begin
            next_r.cmd = FPM_IDLE;
            if (i_wdata == CMD_RESET)
            begin
                // Reset is ignored while programming or bulk erasing
                if (r.op != FPM_PROG && r.op != FPM_BULK)
                begin
                    if (!FAST_VARIANT)
                    begin
                        next_r.rec_cnt = SLOW_CYCLES;
                    end
                    else if (r.err || r.op == FPM_SECT)
                    begin
                        next_r.rec_cnt = RECOVER_CYCLES;
                    end
                    next_r.op  = FPM_READ;
                    next_r.err = 1'b0;
                end
            end
            else
            begin
                case (r.cmd)
                    FPM_IDLE:
                        if (i_addr == UNLOCK_ADDR1 && i_wdata == UNLOCK_DATA1)
                            next_r.cmd = FPM_UNLOCK1;
                    FPM_UNLOCK1:
                        if (i_addr == UNLOCK_ADDR2 && i_wdata == UNLOCK_DATA2)
                            next_r.cmd = FPM_UNLOCK2;
                    FPM_UNLOCK2:
                        if (i_wdata == CMD_PROGRAM)
                            next_r.cmd = FPM_ERASE3;
                        else if (i_wdata == CMD_ERASE_SETUP)
                            next_r.cmd = FPM_ERASE1;
                    FPM_ERASE1:
                        if (i_addr == UNLOCK_ADDR1 && i_wdata == UNLOCK_DATA1)
                            next_r.cmd = FPM_ERASE2;
                    FPM_ERASE2:
                        if (i_wdata == UNLOCK_DATA2)
                            next_r.cmd = FPM_UNLOCK2;
                    FPM_ERASE3:
                        // Program data cycle; protected targets are dropped
                        if (!tgt_prot && r.op == FPM_READ)
                        begin
                            next_r.prog    = 1'b1;
                            next_r.sectors = tgt;
                            next_r.op      = FPM_PROG;
                            next_r.op_cnt  = PROG_CYC;
                        end
                    default:
                        next_r.cmd = FPM_IDLE;
                endcase

                // Erase confirm in FPM_UNLOCK2, reached after either unlock pair
                if (r.cmd == FPM_UNLOCK2 && r.op == FPM_READ
                    && (i_wdata == CMD_BULK || i_wdata == CMD_SECTOR))
                begin
                    next_r.cmd = FPM_IDLE;
                    if (i_wdata == CMD_BULK)
                    begin
                        // Bulk erase only touches unprotected sectors
                        next_r.sectors = ~prot_all;
                        next_r.erase   = |(~prot_all);
                        next_r.op      = FPM_BULK;
                        next_r.op_cnt  = ERASE_CYC;
                    end
                    else if (!tgt_prot)
                    begin
                        next_r.sectors = tgt;
                        next_r.erase   = 1'b1;
                        next_r.op      = FPM_SECT;
                        next_r.op_cnt  = ERASE_CYC;
                    end
                end
            end
        end

        // Reset pin aborts the running operation, the command sequence and the error
        if (!i_reset_pin_b)
        begin
            if (r.op != FPM_READ)
            begin
                next_r.rec_cnt = RECOVER_CYCLES;
            end
            next_r.op  = FPM_READ;
            next_r.cmd = FPM_IDLE;
            next_r.err = 1'b0;
        end

        // Battery indicator only when configured
        next_r.batt = i_batt_cfg & i_supply_below_batt;

        // Registered so busy comes straight from a flop
        next_r.busy = (next_r.op != FPM_READ)
                    || (next_r.rec_cnt != 32'h0);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            r           <= '0;
            r.cmd       <= FPM_IDLE;
            r.op        <= FPM_READ;
            r.space_map <= MAP_BOOT;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_rdata            = r.rdata;

    assign o_main_access      = r.main_acc;
    assign o_second_access    = r.second_acc;
    assign o_ram_access       = r.ram_acc;
    assign o_csr_access       = r.csr_acc;

    assign o_flash_prog       = r.prog;
    assign o_flash_erase      = r.erase;
    assign o_flash_sectors    = r.sectors;

    assign o_busy             = r.busy;
    assign o_error_status_bit = r.err;
    assign o_battery_on       = r.batt;
endmodule
`default_nettype wire

// *** tb/fpm_properties.sv ***
// Port-level checks on the flash protect and memory select block.
// Assumes a bind from the bench top and constant configuration inputs.
`timescale 1ns/1ns
`default_nettype none
module fpm_properties
    import fpm_pkg::*;
#(
    parameter int RECOVER_CYCLES = 20
)
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_reset_pin_b,
    // Bus and selects
    input wire logic [11:0] i_addr,
    input wire logic        i_rd,
    input wire logic        i_fetch,
    input wire logic [7:0]  i_main_sector_select,
    input wire logic [3:0]  i_second_sector_select,
    input wire logic        i_ram_select,
    input wire logic        i_control_register_space,
    // Configuration and power
    input wire logic [7:0]  i_cfg_main_prot,
    input wire logic [3:0]  i_cfg_second_prot,
    input wire logic        i_cfg_security,
    input wire logic        i_batt_cfg,
    input wire logic        i_supply_below_batt,
    // Outputs watched
    input wire logic [7:0]  o_rdata,
    input wire logic [7:0]  o_main_access,
    input wire logic [3:0]  o_second_access,
    input wire logic        o_ram_access,
    input wire logic        o_flash_prog,
    input wire logic        o_flash_erase,
    input wire logic [11:0] o_flash_sectors,
    input wire logic        o_busy,
    input wire logic        o_battery_on
);
    // Slack over recovery, allows a counter that starts late
    localparam int REC_MAX = RECOVER_CYCLES + 10;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_read_main;
        i_rd && i_control_register_space && i_addr[7:0] == OFS_MAIN_PROT;
    endsequence
    sequence s_read_sec;
        i_rd && i_control_register_space && i_addr[7:0] == OFS_SEC_PROT;
    endsequence
    property p_main_prot;
        s_read_main |=> o_rdata == i_cfg_main_prot;
    endproperty
    a_main_prot: assert property (p_main_prot)
        else $error("main protect status wrong");
    property p_sec_prot;
        s_read_sec |=> o_rdata == {i_cfg_security, 3'h0, i_cfg_second_prot};
    endproperty
    a_sec_prot: assert property (p_sec_prot)
        else $error("secondary protect status wrong");
    property p_rdata_idle;
        !i_rd && !i_fetch |=> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without strobe");
    property p_batt_on;
        i_batt_cfg && i_supply_below_batt |=> o_battery_on;
    endproperty
    a_batt_on: assert property (p_batt_on)
        else $error("battery indicator missing");
    property p_ram_first;
        i_rd && i_ram_select && !i_control_register_space |=> o_ram_access
            && o_main_access == 8'h00 && o_second_access == 4'h0;
    endproperty
    a_ram_first: assert property (p_ram_first)
        else $error("sram lost priority");
    property p_sec_first;
        (i_rd || i_fetch) && i_second_sector_select != 4'h0
            |=> o_main_access == 8'h00;
    endproperty
    a_sec_first: assert property (p_sec_first)
        else $error("main sector won over secondary");
    property p_prog_prot;
        o_flash_prog |->
            (o_flash_sectors & {i_cfg_second_prot, i_cfg_main_prot}) == 12'h0;
    endproperty
    a_prog_prot: assert property (p_prog_prot)
        else $error("program hit protected sector");
    property p_erase_prot;
        o_flash_erase |->
            (o_flash_sectors & {i_cfg_second_prot, i_cfg_main_prot}) == 12'h0;
    endproperty
    a_erase_prot: assert property (p_erase_prot)
        else $error("erase hit protected sector");
    property p_pin_abort;
        $rose(i_reset_pin_b) |-> ##[0:REC_MAX] !o_busy;
    endproperty
    a_pin_abort: assert property (p_pin_abort)
        else $error("busy after reset pin");
endmodule
`default_nettype wire

// *** tb/fpm_flash_model.sv ***
// Behavioural flash array feeding read data and timeouts to the block.
// Assumes one-cycle erase pulses carrying a {second,main} sector map.
`timescale 1ns/1ns
`default_nettype none
module fpm_flash_model
(
    // Clock and bench control
    input  wire logic        i_clk,
    input  wire logic        i_fail,
    // Block side
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_main_sel,
    input  wire logic [3:0]  i_second_sel,
    input  wire logic        i_erase,
    input  wire logic [11:0] i_sectors,
    input  wire logic        i_busy,
    // Array answers
    output logic [7:0]       o_rdata,
    output logic             o_timeout
);
    logic [11:0] erased = 12'h000;
    // Only pulsed sectors lose data
    always @(posedge i_clk)
        if (i_erase)
            erased <= erased | i_sectors;
    assign o_rdata = |(erased & {i_second_sel, i_main_sel}) ? 8'hFF
                     : {4'h5, i_addr[3:0]};
    // Timeout only while the block reports busy, recovery included
    assign o_timeout = i_fail & i_busy;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the flash protect and memory select block.
// Assumes the package, checker and flash model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import fpm_pkg::*;
    // Short recovery keeps the run brief
    localparam int RC = 20;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_reset_pin_b = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [7:0]  i_wdata = 8'h00, i_main_sector_select = 8'h00, m_sel = 8'h00;
    logic [3:0]  i_second_sector_select = 4'h0, s_sel = 4'h0;
    logic i_wr = 1'b0, i_rd = 1'b0, i_fetch = 1'b0, i_ram_select = 1'b0;
    logic i_control_register_space = 1'b0, r_sel = 1'b0, c_sel = 1'b0;
    logic i_batt_cfg = 1'b0, i_supply_below_batt = 1'b0, fail_inj = 1'b0;
    wire logic [7:0]  i_flash_rdata, o_rdata, o_main_access;
    wire logic [3:0]  o_second_access;
    wire logic [11:0] o_flash_sectors;
    wire logic i_prog_timeout, o_ram_access, o_csr_access, o_flash_prog;
    wire logic o_flash_erase, o_busy, o_error_status_bit, o_battery_on;
    int fails = 0;
    int cmp_count = 0;
    always #2 i_clk = ~i_clk;
    fpm_top #(.RECOVER_CYCLES(RC), .SLOW_CYCLES(50)) dut_u (.*,
        .i_cfg_main_prot(8'hA5), .i_cfg_second_prot(4'h6),
        .i_cfg_security(1'b1), .i_test_prot_load(1'b0));
    fpm_flash_model u_flash (.i_clk(i_clk), .i_fail(fail_inj),
        .i_addr(i_addr), .i_main_sel(i_main_sector_select),
        .i_second_sel(i_second_sector_select), .i_erase(o_flash_erase),
        .i_sectors(o_flash_sectors), .i_busy(o_busy),
        .o_rdata(i_flash_rdata), .o_timeout(i_prog_timeout));
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One strobe cycle; returns just after the answering edge
    task automatic cyc(input logic [2:0] wrf, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_rd, i_fetch} <= wrf;
        i_addr <= a;
        i_wdata <= d;
        {i_main_sector_select, i_second_sector_select} <= {m_sel, s_sel};
        {i_ram_select, i_control_register_space} <= {r_sel & ~c_sel, c_sel};
        @(posedge i_clk);
        {i_wr, i_rd, i_fetch} <= 3'b000;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        cyc(3'b100, a, d);
    endtask
    task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
        c_sel = 1'b1;
        cyc(3'b010, {4'h0, ofs}, 8'h00);
        chk(13'(o_rdata), 13'(exp));
        c_sel = 1'b0;
    endtask
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
        c_sel = 1'b1;
        wr({4'h0, ofs}, d);
        c_sel = 1'b0;
    endtask
    // Unlocked command; erase setup needs a second unlock pair
    task automatic cmd(input logic [7:0] c, input logic [7:0] last,
                       input logic [7:0] tgt);
        m_sel = tgt;
        wr(UNLOCK_ADDR1, UNLOCK_DATA1);
        wr(UNLOCK_ADDR2, UNLOCK_DATA2);
        wr(UNLOCK_ADDR1, c);
        if (c == CMD_ERASE_SETUP)
        begin
            wr(UNLOCK_ADDR1, UNLOCK_DATA1);
            wr(UNLOCK_ADDR2, UNLOCK_DATA2);
        end
        wr(last == CMD_BULK ? UNLOCK_ADDR1 : 12'h123, last);
    endtask
    // Bounded wait on busy or error; a run-out ends the run
    task automatic wait_lvl(input logic err, input logic lvl, input int n,
                            output int used);
        used = 0;
        while ((err ? o_error_status_bit : o_busy) !== lvl)
        begin
            if (used == n)
            begin
                fails++;
                $display("BAD t=%0t wait ran out", $time);
                tally_and_finish();
            end
            @(posedge i_clk);
            #1;
            used++;
        end
    endtask
    initial
    begin
        int n;
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        reg_rd(OFS_MAIN_PROT, 8'hA5);
        reg_rd(OFS_SEC_PROT, 8'h86);
        reg_rd(OFS_SPACE_MAP, {3'h0, MAP_RESET});
        reg_wr(OFS_MAIN_PROT, 8'h00);
        reg_rd(OFS_MAIN_PROT, 8'hA5);
        reg_rd(8'hC4, 8'h00);
        m_sel = 8'h02;
        wr(12'h000, CMD_RESET);
        $display("test registers done");
        for (int b = 0; b < 5; b++)
            for (int k = 0; k < 2; k++)
            begin
                reg_wr(OFS_SPACE_MAP, k ? 8'(5'h1F ^ (5'h01 << b))
                                        : 8'(5'h01 << b));
                r_sel = (b == 0);
                s_sel = (b == 1 || b == 3) ? 4'h1 : 4'h0;
                m_sel = (b == 2 || b == 4) ? 8'h01 : 8'h00;
                cyc(b < 3 ? 3'b001 : 3'b010, 12'h100, 8'h00);
                chk({o_ram_access, o_second_access, o_main_access},
                    k ? 13'h0 : {r_sel, s_sel, m_sel});
            end
        reg_wr(OFS_SPACE_MAP, 8'h1F);
        $display("test space map done");
        // Ram, secondary and main selected at once, then ram dropped, then register space against main
        r_sel = 1'b1;
        s_sel = 4'h1;
        m_sel = 8'h01;
        cyc(3'b010, 12'h080, 8'h00);
        chk({o_ram_access, o_second_access, o_main_access}, 13'h1000);
        r_sel = 1'b0;
        cyc(3'b010, 12'h080, 8'h00);
        chk({o_ram_access, o_second_access, o_main_access}, 13'h0100);
        s_sel = 4'h0;
        c_sel = 1'b1;
        cyc(3'b010, 12'h0F0, 8'h00);
        chk({o_csr_access, 4'h0, o_main_access}, 13'h1000);
        c_sel = 1'b0;
        $display("test priority done");
        cmd(CMD_PROGRAM, 8'h3C, 8'h02);
        chk({o_flash_prog, o_flash_sectors}, 13'h1002);
        wr(12'h000, CMD_RESET);
        chk(13'(o_busy), 13'h1);
        wait_lvl(1'b0, 1'b0, 200, n);
        cmd(CMD_PROGRAM, 8'h3C, 8'h01);
        chk(13'({o_flash_prog, o_busy}), 13'h0);
        cmd(CMD_ERASE_SETUP, CMD_SECTOR, 8'h01);
        chk(13'({o_flash_erase, o_busy}), 13'h0);
        cyc(3'b010, 12'h007, 8'h00);
        chk(13'(o_rdata), 13'h057);
        cmd(CMD_ERASE_SETUP, CMD_SECTOR, 8'h02);
        chk({o_flash_erase, o_flash_sectors}, 13'h1002);
        wr(12'h000, CMD_RESET);
        wait_lvl(1'b0, 1'b0, RC + 20, n);
        chk(13'(n >= RC - 5 && n <= RC + 5), 13'h1);
        $display("test program and erase done");
        fail_inj = 1'b1;
        cmd(CMD_PROGRAM, 8'h3C, 8'h02);
        wait_lvl(1'b1, 1'b1, 200, n);
        wait_lvl(1'b0, 1'b0, 200, n);
        fail_inj = 1'b0;
        cyc(3'b010, 12'h005, 8'h00);
        chk(13'({o_error_status_bit, o_rdata}), 13'h120);
        wr(12'h000, CMD_RESET);
        chk(13'(o_busy), 13'h1);
        wait_lvl(1'b0, 1'b0, RC + 20, n);
        chk(13'(o_error_status_bit), 13'h0);
        $display("test error done");
        cmd(CMD_ERASE_SETUP, CMD_BULK, 8'h02);
        wr(12'h000, CMD_RESET);
        chk(13'(o_busy), 13'h1);
        @(posedge i_clk);
        i_reset_pin_b <= 1'b0;
        repeat (RC) @(posedge i_clk);
        i_reset_pin_b <= 1'b1;
        #1;
        wait_lvl(1'b0, 1'b0, RC + 10, n);
        $display("test reset pin done");
        for (int j = 0; j < 4; j++)
        begin
            @(posedge i_clk);
            i_batt_cfg <= j[0];
            i_supply_below_batt <= j[1];
            repeat (2) @(posedge i_clk);
            #1;
            chk(13'(o_battery_on), 13'(j == 3));
        end
        $display("test battery done");
        tally_and_finish();
    end
endmodule
bind fpm_top fpm_properties #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_props (.*);
`default_nettype wire
